// file: include/ssr_pkg.sv
package ssr_pkg;

  // serial word and frame lengths, in serial clocks
  localparam int unsigned WORD_W = 24;
  localparam logic [4:0] FRAME_BITS_NONE = 5'h00;
  localparam logic [4:0] FRAME_BITS_CTRL = 5'h08;
  localparam logic [4:0] FRAME_BITS_LOOP = 5'h10;
  localparam logic [4:0] FRAME_BITS_REF = 5'h18;
  localparam logic [4:0] FRAME_BITS_MAX = 5'h1F;

  // control register bit positions (8-bit write)
  localparam int unsigned CTRL_ADC_SAMPLE = 7;
  localparam int unsigned CTRL_READ_ADC = 6;
  localparam int unsigned CTRL_RESERVED = 5;
  localparam int unsigned CTRL_CHAN = 4;
  localparam int unsigned CTRL_OUT_A = 3;
  localparam int unsigned CTRL_OUT_B = 2;
  localparam int unsigned CTRL_OUT_C = 1;
  localparam int unsigned CTRL_READ_CNT = 0;

  // reference divider register bit positions (24-bit write)
  localparam int unsigned REF_CNT_SAMPLE = 23;
  localparam int unsigned REF_BAND = 22;
  localparam int unsigned REF_WINDOW = 21;
  localparam int unsigned REF_DIV_W = 14;

  // loop divider register (16-bit write)
  localparam int unsigned LOOP_DIV_W = 16;

  // readback word layouts, bit 23 goes out first
  localparam int unsigned ADC_W = 6;
  localparam int unsigned CNT_W = 22;
  localparam int unsigned ADC_PAD_W = 15;

  // reset values
  localparam logic RESET_BIT = 1'h0;
  localparam logic [REF_DIV_W-1:0] REF_DIV_RESET = 14'h0000;
  localparam logic [LOOP_DIV_W-1:0] LOOP_DIV_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [ADC_W-1:0] ADC_RESET = 6'h00;

  // converter time: reference oscillator periods; clk is the reference
  localparam int unsigned ADC_CONV_PERIODS = 3584;
  localparam int unsigned REF_PERIODS_PER_CLK = 1;
  localparam int unsigned ADC_CONV_CYCLES = ADC_CONV_PERIODS / REF_PERIODS_PER_CLK;
  localparam logic [11:0] ADC_CONV_LAST = 12'(ADC_CONV_CYCLES - 1);
  localparam logic [11:0] ADC_TIMER_RESET = 12'h000;

endpackage

// file: rtl/ssr_adc_seq.sv
module ssr_adc_seq (
  // clock and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic rst_b,
  // control
  input wire logic sample_request,
  input wire logic [ssr_pkg::ADC_W-1:0] sample_value,
  // result
  output logic conv_done,
  output logic [ssr_pkg::ADC_W-1:0] conv_result
);

  logic [11:0] timer_r;

  // a low request holds the converter initialised, so the flag stays 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_r <= ssr_pkg::ADC_TIMER_RESET;
      conv_done <= ssr_pkg::RESET_BIT;
    end else if (clk_en) begin
      if (!sample_request) begin
        timer_r <= ssr_pkg::ADC_TIMER_RESET; // [RULE_16]
        conv_done <= 1'b0; // [RULE_01]
      end else if (!conv_done) begin
        if (timer_r == ssr_pkg::ADC_CONV_LAST) begin
          conv_done <= 1'b1; // [RULE_18]
        end else begin
          timer_r <= timer_r + 12'h001;
        end
      end
    end
  end

  // value is plain unsigned binary straight from the front end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_result <= ssr_pkg::ADC_RESET;
    end else if (clk_en && sample_request && !conv_done && timer_r == ssr_pkg::ADC_CONV_LAST) begin
      conv_result <= sample_value; // [RULE_03]
    end
  end

endmodule

// file: rtl/ssr_top.sv
// What this block does
// [RULE_01] conversion-done flag reads 0 unless a valid conversion result is held
// [RULE_02] converter readback first byte: done flag, input one, six-bit value
// [RULE_03] converter value is unsigned binary, zero to full scale
// [RULE_04] second byte of converter readback: input two at MSB, rest don't-care
// [RULE_05] input two is also visible on a nine-bit converter readback
// [RULE_06] count-done flag reads 0 until a valid frequency count is held
// [RULE_07] count readback holds done flag, input two and binary count
// [RULE_08] general outputs change only when a control write frame ends
// [RULE_09] written registers keep their values until rewritten
// [RULE_10] host clears band select for HF/MF, sets it for VHF
// [RULE_11] reference divider register is loaded by a 24-bit frame
// [RULE_12] loop divider register is loaded by a 16-bit frame
// [RULE_13] host normally picks wide count window for HF/MF, narrow for VHF
// [RULE_14] with converter readback requested, both inputs are captured at frame start
// [RULE_15] host shifts 8 bits for input one, 9 or 16 for both
// [RULE_16] clearing the sample request initialises the converter
// [RULE_17] sample request is set only by the host, never cleared by the device
// [RULE_18] done flag rises 3584 reference periods after sample request is set
// [RULE_19] host reads converter with readback set, sample kept, 8 bits out
// [RULE_20] readback request blocks all writes and clears after the read frame
// [RULE_21] both readback requests set: converter read wins, count request dropped
// [RULE_22] host sets the matching readback request before reading
// [RULE_23] host reads the count register with a 24-bit frame
// [RULE_24] host does not set count sampling while converter sampling is set
// [RULE_25] readback data leaves MSB first, one bit per serial clock
module ssr_top (
  // clock and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic rst_b,
  // serial link
  input wire logic serial_clk,
  input wire logic serial_frame_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // digital input pins
  input wire logic gp_in_1,
  input wire logic gp_in_2,
  // converter front end
  input wire logic [ssr_pkg::ADC_W-1:0] adc_sample_value,
  output logic adc_channel_sel,
  output logic adc_sample_request,
  // frequency counter
  input wire logic [ssr_pkg::CNT_W-1:0] count_value,
  input wire logic count_done_in,
  output logic count_sample_request,
  output logic count_window_wide,
  output logic band_select,
  output logic count_abort,
  output logic [ssr_pkg::REF_DIV_W-1:0] ref_divide,
  output logic [ssr_pkg::LOOP_DIV_W-1:0] loop_divide,
  // general outputs
  output logic gpo_a_o,
  output logic gpo_a_oe,
  output logic gpo_b,
  output logic gpo_c
);

  // ---- link domain (serial_clk) ----
  logic link_idle;
  logic fresh_r;
  logic frame_id_r;
  logic [4:0] bit_cnt_r;
  logic [ssr_pkg::WORD_W-1:0] rx_r;

  // ---- clk domain ----
  logic [1:0] sel_sync_r;
  logic sel_prev_r;
  logic [1:0] in1_sync_r;
  logic [1:0] in2_sync_r;
  logic frame_fall;
  logic frame_rise;
  logic seen_id_r;
  logic new_frame;
  logic read_adc_r;
  logic read_cnt_r;
  logic [ssr_pkg::WORD_W-1:0] tx_word_r;
  logic [ssr_pkg::WORD_W-1:0] snapshot;
  logic adc_done;
  logic [ssr_pkg::ADC_W-1:0] adc_result;
  logic count_done_flag;

  function automatic logic tx_bit(input logic [ssr_pkg::WORD_W-1:0] w, input logic [4:0] n);
    tx_bit = (n < ssr_pkg::FRAME_BITS_REF) ? w[5'h17 - n] : 1'b0;
  endfunction

  // frame start is seen asynchronously; the clock may stand still between frames
  assign link_idle = ~rst_b | serial_frame_select_n;

  always_ff @(posedge serial_clk or posedge link_idle) begin
    if (link_idle) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // toggles once per clocked frame so a frame with no clocks commits nothing
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_id_r <= ssr_pkg::RESET_BIT;
    end else if (!serial_frame_select_n && fresh_r) begin
      frame_id_r <= ~frame_id_r;
    end
  end

  // shift in; only the last 24 bits and the length matter
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r <= ssr_pkg::WORD_RESET;
      bit_cnt_r <= ssr_pkg::FRAME_BITS_NONE;
    end else if (!serial_frame_select_n) begin
      rx_r <= {rx_r[ssr_pkg::WORD_W-2:0], serial_data_in};
      if (fresh_r) begin
        bit_cnt_r <= 5'h01;
      end else if (bit_cnt_r != ssr_pkg::FRAME_BITS_MAX) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // shift out on the rising serial edge; host samples on the falling one.
  // tx_word_r is loaded at frame start and held quiet for the whole frame.
  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_out <= ssr_pkg::RESET_BIT;
    end else if (!serial_frame_select_n) begin
      if (fresh_r) begin
        serial_data_out <= tx_word_r[ssr_pkg::WORD_W-1]; // [RULE_25]
      end else begin
        serial_data_out <= tx_bit(tx_word_r, bit_cnt_r); // [RULE_25]
      end
    end
  end

  // frame select and input pins arrive from outside this domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_r <= 2'h3;
      sel_prev_r <= 1'b1;
      in1_sync_r <= 2'h0;
      in2_sync_r <= 2'h0;
    end else if (clk_en) begin
      sel_sync_r <= {sel_sync_r[0], serial_frame_select_n};
      sel_prev_r <= sel_sync_r[1];
      in1_sync_r <= {in1_sync_r[0], gp_in_1};
      in2_sync_r <= {in2_sync_r[0], gp_in_2};
    end
  end

  assign frame_fall = clk_en & sel_prev_r & ~sel_sync_r[1];
  assign frame_rise = clk_en & ~sel_prev_r & sel_sync_r[1];
  // link flops are quiet here: no serial clock runs while the frame is idle
  assign new_frame = frame_rise & (frame_id_r != seen_id_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_id_r <= ssr_pkg::RESET_BIT;
    end else if (frame_rise) begin
      seen_id_r <= frame_id_r;
    end
  end

  // count is only valid while count sampling is requested
  assign count_done_flag = count_sample_request & count_done_in; // [RULE_06]

  // readback word built from the state at frame start
  always_comb begin
    snapshot = ssr_pkg::WORD_RESET;
    if (read_adc_r) begin
      // converter read takes precedence over a pending count read
      snapshot = {adc_done, in1_sync_r[1], adc_result, in2_sync_r[1], // [RULE_02] [RULE_14] [RULE_21]
                  {ssr_pkg::ADC_PAD_W{1'b0}}}; // [RULE_04] [RULE_05]
    end else if (read_cnt_r) begin
      snapshot = {count_done_flag, in2_sync_r[1], count_value}; // [RULE_07]
    end
  end

  // host must allow three clk periods after frame start before the first serial edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_word_r <= ssr_pkg::WORD_RESET;
    end else if (frame_fall) begin
      tx_word_r <= snapshot; // [RULE_14]
    end
  end

  // control register and readback requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_sample_request <= ssr_pkg::RESET_BIT;
      adc_channel_sel <= ssr_pkg::RESET_BIT;
      read_adc_r <= ssr_pkg::RESET_BIT;
      read_cnt_r <= ssr_pkg::RESET_BIT;
      gpo_a_oe <= 1'b1;
      gpo_b <= ssr_pkg::RESET_BIT;
      gpo_c <= ssr_pkg::RESET_BIT;
    end else if (new_frame) begin
      if (read_adc_r || read_cnt_r) begin
        // a read frame writes nothing; both requests retire together
        read_adc_r <= 1'b0; // [RULE_20] [RULE_21]
        read_cnt_r <= 1'b0; // [RULE_20]
      end else if (bit_cnt_r == ssr_pkg::FRAME_BITS_CTRL) begin
        adc_sample_request <= rx_r[ssr_pkg::CTRL_ADC_SAMPLE]; // [RULE_16] [RULE_17]
        adc_channel_sel <= rx_r[ssr_pkg::CTRL_CHAN];
        read_adc_r <= rx_r[ssr_pkg::CTRL_READ_ADC];
        read_cnt_r <= rx_r[ssr_pkg::CTRL_READ_CNT];
        gpo_a_oe <= ~rx_r[ssr_pkg::CTRL_OUT_A]; // [RULE_08]
        gpo_b <= rx_r[ssr_pkg::CTRL_OUT_B]; // [RULE_08]
        gpo_c <= rx_r[ssr_pkg::CTRL_OUT_C]; // [RULE_08]
      end
    end
  end

  // output A is open drain: it only ever pulls low
  assign gpo_a_o = 1'b0;

  // reference divider register; values persist until rewritten
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_sample_request <= ssr_pkg::RESET_BIT;
      band_select <= ssr_pkg::RESET_BIT;
      count_window_wide <= ssr_pkg::RESET_BIT;
      ref_divide <= ssr_pkg::REF_DIV_RESET;
    end else if (new_frame && !read_adc_r && !read_cnt_r && bit_cnt_r == ssr_pkg::FRAME_BITS_REF) begin
      count_sample_request <= rx_r[ssr_pkg::REF_CNT_SAMPLE]; // [RULE_11] [RULE_09]
      band_select <= rx_r[ssr_pkg::REF_BAND];
      count_window_wide <= rx_r[ssr_pkg::REF_WINDOW];
      ref_divide <= rx_r[ssr_pkg::REF_DIV_W-1:0]; // [RULE_11]
    end
  end

  // a reference write while both samplers run aborts the counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_abort <= ssr_pkg::RESET_BIT;
    end else if (clk_en) begin
      count_abort <= new_frame && !read_adc_r && !read_cnt_r && bit_cnt_r == ssr_pkg::FRAME_BITS_REF
                     && adc_sample_request && count_sample_request;
    end
  end

  // loop divider register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_divide <= ssr_pkg::LOOP_DIV_RESET;
    end else if (new_frame && !read_adc_r && !read_cnt_r && bit_cnt_r == ssr_pkg::FRAME_BITS_LOOP) begin
      loop_divide <= rx_r[ssr_pkg::LOOP_DIV_W-1:0]; // [RULE_12] [RULE_09]
    end
  end

  ssr_adc_seq u_adc_seq (
    .clk(clk),
    .clk_en(clk_en),
    .rst_b(rst_b),
    .sample_request(adc_sample_request),
    .sample_value(adc_sample_value),
    .conv_done(adc_done),
    .conv_result(adc_result)
  );

endmodule

// file: verification/ssr_assertions.sv
module ssr_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic serial_clk,
  input wire logic serial_frame_select_n,
  input wire logic serial_data_out,
  // outputs
  input wire logic adc_sample_request,
  input wire logic count_sample_request,
  input wire logic count_abort,
  input wire logic [ssr_pkg::REF_DIV_W-1:0] ref_divide,
  input wire logic [ssr_pkg::LOOP_DIV_W-1:0] loop_divide,
  input wire logic gpo_a_o,
  input wire logic gpo_a_oe,
  input wire logic gpo_b,
  input wire logic gpo_c
);
  logic [2:0] hi_cnt_r;
  logic ended;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles since frame rose; sync latency gives a window, not one edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt_r <= 3'h0;
    end else if (!serial_frame_select_n) begin
      hi_cnt_r <= 3'h0;
    end else if (hi_cnt_r != 3'h7) begin
      hi_cnt_r <= hi_cnt_r + 3'h1;
    end
  end
  assign ended = hi_cnt_r inside {[3'h2:3'h6]};
  sequence s_low6;
    (!serial_frame_select_n) [*6];
  endsequence
  sequence s_both_req;
    adc_sample_request && count_sample_request;
  endsequence
  gpo_update_a: assert property ($changed({gpo_a_oe, gpo_b, gpo_c}) |-> ended)
    else $error("gpo moved away from frame end");
  cfg_update_a: assert property ($changed({ref_divide, loop_divide}) |-> ended)
    else $error("divider moved away from frame end");
  cfg_hold_a: assert property (s_low6 |-> $stable({ref_divide, loop_divide, adc_sample_request}))
    else $error("config moved inside a frame");
  req_hold_a: assert property ($fell(adc_sample_request) |-> ended)
    else $error("sample request dropped by itself");
  sdo_time_a: assert property ($changed(serial_data_out) |-> serial_clk || serial_frame_select_n)
    else $error("data out moved off serial clock");
  gpo_a_low_a: assert property (gpo_a_o == 1'b0)
    else $error("open drain pin driven high");
  abort_src_a: assert property (count_abort |-> $past(adc_sample_request && count_sample_request))
    else $error("abort without both samplers");
  abort_pulse_a: assert property (count_abort |=> !count_abort)
    else $error("abort longer than a cycle");
  cover property (s_both_req ##[1:60] count_abort);
endmodule
bind ssr_top ssr_assertions i_ssr_assertions (.clk(clk), .rst_b(rst_b), .serial_clk(serial_clk),
  .serial_frame_select_n(serial_frame_select_n), .serial_data_out(serial_data_out),
  .adc_sample_request(adc_sample_request), .count_sample_request(count_sample_request),
  .count_abort(count_abort), .ref_divide(ref_divide), .loop_divide(loop_divide), .gpo_a_o(gpo_a_o),
  .gpo_a_oe(gpo_a_oe), .gpo_b(gpo_b), .gpo_c(gpo_c));

// file: verification/ssr_host.sv
module ssr_host (
  // link
  output logic sclk,
  output logic sel_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  // n bits msb first; clock only inside the frame
  task automatic xfer(input int n, input logic [23:0] d, output logic [23:0] q);
    q = 24'h000000;
    #7 sel_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
      q = {q[22:0], sdo};
    end
    sdi = ~sdi;
    #40 sel_n = 1'b1;
    #200;
  endtask
endmodule

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, sel_n, sdi, sdo, chan, areq, creq, wide, band, abort, ga_o, ga_oe, gb, gc;
  logic in1 = 1'b1;
  logic in2 = 1'b0;
  logic cdone = 1'b1;
  logic [ssr_pkg::ADC_W-1:0] adc = 6'h2A;
  logic [ssr_pkg::CNT_W-1:0] cnt = 22'h002710;
  logic [ssr_pkg::REF_DIV_W-1:0] rdiv;
  logic [ssr_pkg::LOOP_DIV_W-1:0] ldiv;
  logic [23:0] q;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_abort = 0;
  always #20 clk = ~clk;
  // abort is a one-cycle pulse; look at it away from its launching edge
  always @(negedge clk) begin
    if (abort === 1'b1) n_abort++;
  end
  ssr_top i_ssr_top (.clk(clk), .clk_en(1'b1), .rst_b(rst_b), .serial_clk(sclk), .serial_frame_select_n(sel_n),
    .serial_data_in(sdi), .serial_data_out(sdo), .gp_in_1(in1), .gp_in_2(in2), .adc_sample_value(adc),
    .adc_channel_sel(chan), .adc_sample_request(areq), .count_value(cnt), .count_done_in(cdone),
    .count_sample_request(creq), .count_window_wide(wide), .band_select(band), .count_abort(abort),
    .ref_divide(rdiv), .loop_divide(ldiv), .gpo_a_o(ga_o), .gpo_a_oe(ga_oe), .gpo_b(gb), .gpo_c(gc));
  ssr_host i_ssr_host (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(sdo));
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_rd(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int n, input logic [23:0] d);
    @(negedge clk);
    i_ssr_host.xfer(n, d, q);
    repeat (6) @(negedge clk);
  endtask
  task automatic rd(input int n);
    wr(n, 24'h000000);
  endtask
  task automatic tend(input string s);
    $display("test %s done, mismatches %0d", s, fails);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk_out(32'({ga_o, ga_oe, gb, gc, areq, creq}), 32'h10);
    chk_out(32'({rdiv, ldiv}), 32'h0);
    tend("reset");
    wr(8, 24'h0E);
    chk_out(32'({ga_o, ga_oe, gb, gc}), 32'h3);
    wr(9, 24'h000);
    chk_out(32'({ga_oe, gb, gc}), 32'h3);
    tend("outputs");
    wr(24, 24'h4003E8);
    chk_out(32'({creq, band, wide, rdiv}), 32'h083E8);
    wr(16, 24'h07AC);
    chk_out(32'(ldiv), 32'h07AC);
    wr(8, 24'h10);
    chk_out(32'({rdiv, ldiv, chan, areq}), 32'h0FA01EB2);
    tend("config");
    wr(8, 24'h90);
    chk_out(32'({chan, areq}), 32'h3);
    // read well before the conversion time: done must still be low
    wr(8, 24'hD0);
    rd(8);
    chk_rd(q >> 6, 24'h1);
    wr(8, 24'hD0);
    repeat (3520) @(negedge clk);
    rd(8);
    chk_rd(q, 24'hEA);
    in2 = 1'b1;
    wr(8, 24'hD0);
    rd(9);
    chk_rd(q, 24'h1D5);
    wr(8, 24'hD1);
    wr(16, 24'h1234);
    chk_rd(q >> 7, 24'h1D5);
    chk_out(32'({ldiv, chan, areq}), 32'h1EB3);
    wr(8, 24'h10);
    wr(8, 24'h50);
    rd(8);
    chk_rd(q >> 6, 24'h1);
    chk_out(32'(areq), 32'h0);
    tend("adc");
    wr(24, 24'hA003E8);
    in2 = 1'b0;
    wr(8, 24'h11);
    rd(24);
    chk_rd(q, 24'h802710);
    cdone = 1'b0;
    wr(8, 24'h11);
    rd(24);
    chk_rd(q, 24'h002710);
    wr(8, 24'h90);
    wr(24, 24'hA003E8);
    chk_out(32'({areq, creq}), 32'h3);
    chk_out(32'(n_abort), 32'h1);
    tend("count");
    summarize();
  end
endmodule
